/* File: src/jdbms_jog_brake_ctrl.sv */
`timescale 1ns/1ps
// Function
// R1: Jog function code runs motor at jog frequency
// R2: Jog output frequency clamped to 10 Hz
// R3: Jog output only with jog and run together
// R4: Jog steps straight to frequency, no ramp
// R5: Jog ends by coast, decel or DC brake
// R6: No jog if frequency zero or below start
// R7: Panel run key jogs only in terminal mode
// R8: Jog input released leaves jog, back to stop
// R9: DC-brake function code enables injection braking
// R10: Brake delay held within 0.1 to 5.0 s; code clamps only above 5.0 s and accepts 0
// R11: Brake force held 0 to 100 percent, applied
// R12: Terminal run: brake, then ramp back on release
// R13: Keypad run: brake, output stays off after release
// R14: Keypad run with delay: coast, then brake
// R15: Motor-two function code selects second parameter set
// R16: Parameter set changes only while stopped
// R17: Select released means main parameter set
// R18: Outside party avoids holding brake input continuously
// R19: Each terminal decoded by its function code
module jdbms_jog_brake_ctrl #(
  parameter int DB_TICK_CYCLES = jdbms_pkg::DB_TICK_CYCLES,
  parameter int RAMP_TICK_CYCLES = jdbms_pkg::RAMP_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire jdbms_pkg::jdbms_pins_t pinsIn,
  output jdbms_pkg::jdbms_drive_t driveOut
);

  localparam int NT = jdbms_pkg::NUM_TERMINALS;

  jdbms_pkg::jdbms_pins_t pinsMeta_r;
  jdbms_pkg::jdbms_pins_t pins_r;
  logic [NT-1:0][7:0] funcCode_r;
  logic [15:0] jogFreq_r;
  logic [1:0] jogStop_r;
  logic [1:0] runSrc_r;
  logic [15:0] startFreq_r;
  logic [7:0] dbDelay_r;
  logic [6:0] dbForce_r;
  logic [15:0] motor1Freq_r;
  logic [15:0] motor2Freq_r;
  jdbms_pkg::jdbms_state_t state_r;
  logic [15:0] freq_r;
  logic set2_r;
  logic fromKeypad_r;
  logic [31:0] rampCnt_r;
  logic rampTick;
  logic [31:0] dbCnt_r;
  logic [7:0] dbUnits_r;
  logic ack_r;
  logic [31:0] rdData_r;
  jdbms_pkg::jdbms_drive_t drive_r;
  logic [NT-1:0] jogHit;
  logic [NT-1:0] dbHit;
  logic [NT-1:0] setHit;
  logic jogIn;
  logic dbIn;
  logic setIn;
  logic busReq;
  logic wrEn;
  logic [31:0] rdData;
  logic [31:0] wrMask;
  logic termRun;
  logic jogRunCmd;
  logic jogAllowed;
  logic normalRun;
  logic [15:0] jogLim;
  logic [15:0] target;
  logic delayDone;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      pinsMeta_r <= '0;
      pins_r <= '0;
    end else begin
      pinsMeta_r <= pinsIn;
      pins_r <= pinsMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal function decode
  genvar i;
  generate
    for (i = 0; i < NT; i++) begin : g_term
      assign jogHit[i] = pins_r.terminal[i] && (funcCode_r[i] == jdbms_pkg::FUNC_JOG); // see R19
      assign dbHit[i] = pins_r.terminal[i] && (funcCode_r[i] == jdbms_pkg::FUNC_DC_BRAKE); // see R19
      assign setHit[i] = pins_r.terminal[i] && (funcCode_r[i] == jdbms_pkg::FUNC_MOTOR2); // see R19
    end
  endgenerate

  assign jogIn = |jogHit; // see R1
  assign dbIn = |dbHit; // see R9
  assign setIn = |setHit; // see R15

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrEn = busReq && wb_we_i;
  assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    rdData = '0;
    case (wb_adr_i)
      jdbms_pkg::ADR_FUNC_LO: rdData = {funcCode_r[3], funcCode_r[2], funcCode_r[1], funcCode_r[0]};
      jdbms_pkg::ADR_FUNC_HI: rdData = {24'h000000, funcCode_r[4]};
      jdbms_pkg::ADR_JOG_FREQ: rdData = {16'h0000, jogFreq_r};
      jdbms_pkg::ADR_JOG_STOP: rdData = {30'h00000000, jogStop_r};
      jdbms_pkg::ADR_RUN_SRC: rdData = {30'h00000000, runSrc_r};
      jdbms_pkg::ADR_START_FREQ: rdData = {16'h0000, startFreq_r};
      jdbms_pkg::ADR_DB_DELAY: rdData = {24'h000000, dbDelay_r};
      jdbms_pkg::ADR_DB_FORCE: rdData = {25'h0000000, dbForce_r};
      jdbms_pkg::ADR_MOTOR1_FREQ: rdData = {16'h0000, motor1Freq_r};
      jdbms_pkg::ADR_MOTOR2_FREQ: rdData = {16'h0000, motor2Freq_r};
      jdbms_pkg::ADR_STATUS: begin
        rdData[jdbms_pkg::STAT_FREQ_LSB +: 16] = freq_r;
        rdData[jdbms_pkg::STAT_OUT_EN_BIT] = drive_r.outEnable;
        rdData[jdbms_pkg::STAT_BRAKE_BIT] = drive_r.brakeOn;
        rdData[jdbms_pkg::STAT_SET2_BIT] = set2_r;
        rdData[jdbms_pkg::STAT_STATE_LSB +: 3] = state_r;
      end
      default: rdData = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdData_r <= '0;
    end else begin
      ack_r <= busReq;
      rdData_r <= busReq ? rdData : '0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  ////////////////////////////////////////////////////////////////////////////
  // Setting registers
  always_ff @(posedge clk) begin
    logic [31:0] v;
    v = '0;
    if (reset) begin
      funcCode_r <= {NT{jdbms_pkg::RST_FUNC_CODE}};
      jogFreq_r <= jdbms_pkg::RST_JOG_FREQ;
      jogStop_r <= jdbms_pkg::RST_JOG_STOP;
      runSrc_r <= jdbms_pkg::RST_RUN_SRC;
      startFreq_r <= jdbms_pkg::RST_START_FREQ;
      dbDelay_r <= jdbms_pkg::RST_DB_DELAY;
      dbForce_r <= jdbms_pkg::RST_DB_FORCE;
      motor1Freq_r <= jdbms_pkg::RST_MOTOR_FREQ;
      motor2Freq_r <= jdbms_pkg::RST_MOTOR_FREQ;
    end else if (wrEn) begin
      case (wb_adr_i)
        jdbms_pkg::ADR_FUNC_LO: begin
          v = merge({funcCode_r[3], funcCode_r[2], funcCode_r[1], funcCode_r[0]}, wb_dat_i, wrMask);
          funcCode_r[3:0] <= v;
        end
        jdbms_pkg::ADR_FUNC_HI: begin
          v = merge({24'h000000, funcCode_r[4]}, wb_dat_i, wrMask);
          funcCode_r[4] <= v[7:0];
        end
        jdbms_pkg::ADR_JOG_FREQ: begin
          v = merge({16'h0000, jogFreq_r}, wb_dat_i, wrMask);
          jogFreq_r <= v[15:0];
        end
        jdbms_pkg::ADR_JOG_STOP: begin
          v = merge({30'h00000000, jogStop_r}, wb_dat_i, wrMask);
          jogStop_r <= v[1:0];
        end
        jdbms_pkg::ADR_RUN_SRC: begin
          v = merge({30'h00000000, runSrc_r}, wb_dat_i, wrMask);
          runSrc_r <= v[1:0];
        end
        jdbms_pkg::ADR_START_FREQ: begin
          v = merge({16'h0000, startFreq_r}, wb_dat_i, wrMask);
          startFreq_r <= v[15:0];
        end
        jdbms_pkg::ADR_DB_DELAY: begin
          v = merge({24'h000000, dbDelay_r}, wb_dat_i, wrMask);
          dbDelay_r <= (v > 32'(jdbms_pkg::DB_DELAY_MAX)) ? jdbms_pkg::DB_DELAY_MAX : v[7:0]; // see R10
        end
        jdbms_pkg::ADR_DB_FORCE: begin
          v = merge({25'h0000000, dbForce_r}, wb_dat_i, wrMask);
          dbForce_r <= (v > 32'(jdbms_pkg::DB_FORCE_MAX)) ? jdbms_pkg::DB_FORCE_MAX : v[6:0]; // see R11
        end
        jdbms_pkg::ADR_MOTOR1_FREQ: begin
          v = merge({16'h0000, motor1Freq_r}, wb_dat_i, wrMask);
          motor1Freq_r <= v[15:0];
        end
        jdbms_pkg::ADR_MOTOR2_FREQ: begin
          v = merge({16'h0000, motor2Freq_r}, wb_dat_i, wrMask);
          motor2Freq_r <= v[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp tick and brake delay timing
  assign rampTick = (rampCnt_r == 32'(RAMP_TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (reset || rampTick) begin
      rampCnt_r <= '0;
    end else begin
      rampCnt_r <= rampCnt_r + 32'h00000001;
    end
  end

  // Delay runs only in the coast and jog-brake states and restarts on entry
  always_ff @(posedge clk) begin
    if (reset || (state_r != jdbms_pkg::ST_COAST && state_r != jdbms_pkg::ST_JOG_BRAKE)) begin
      dbCnt_r <= '0;
      dbUnits_r <= '0;
    end else if (dbCnt_r == 32'(DB_TICK_CYCLES - 1)) begin
      dbCnt_r <= '0;
      if (!delayDone) begin
        dbUnits_r <= dbUnits_r + 8'h01;
      end
    end else begin
      dbCnt_r <= dbCnt_r + 32'h00000001;
    end
  end

  assign delayDone = (dbUnits_r >= dbDelay_r);

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  assign termRun = pins_r.forwardRun || pins_r.reverseRun;
  assign jogRunCmd = jogIn && (termRun || (runSrc_r == jdbms_pkg::RUN_SRC_TERMINAL && pins_r.keypadRun)); // see R3 R7
  assign jogAllowed = (jogFreq_r != 16'h0000) && (jogFreq_r >= startFreq_r); // see R6
  assign normalRun = (runSrc_r == jdbms_pkg::RUN_SRC_TERMINAL) ? termRun : pins_r.keypadRun;
  assign jogLim = (jogFreq_r > jdbms_pkg::JOG_FREQ_LIMIT) ? jdbms_pkg::JOG_FREQ_LIMIT : jogFreq_r; // see R2
  assign target = set2_r ? motor2Freq_r : motor1Freq_r; // see R15 R17

  function automatic logic [15:0] rampTo(input logic [15:0] cur, input logic [15:0] tgt);
    if (cur < tgt) begin
      rampTo = ((tgt - cur) > jdbms_pkg::RAMP_STEP) ? cur + jdbms_pkg::RAMP_STEP : tgt;
    end else begin
      rampTo = ((cur - tgt) > jdbms_pkg::RAMP_STEP) ? cur - jdbms_pkg::RAMP_STEP : tgt;
    end
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= jdbms_pkg::ST_IDLE;
      freq_r <= '0;
      set2_r <= 1'b0;
      fromKeypad_r <= 1'b0;
    end else begin
      case (state_r)
        jdbms_pkg::ST_IDLE: begin
          freq_r <= '0;
          set2_r <= setIn; // see R16 R17
          if (jogRunCmd && jogAllowed) begin
            freq_r <= jogLim; // see R1 R4
            state_r <= jdbms_pkg::ST_JOG;
          end else if (normalRun && !dbIn) begin
            fromKeypad_r <= (runSrc_r != jdbms_pkg::RUN_SRC_TERMINAL);
            state_r <= jdbms_pkg::ST_RUN;
          end
        end
        jdbms_pkg::ST_RUN: begin
          if (!normalRun) begin
            state_r <= jdbms_pkg::ST_DECEL;
          end else if (dbIn) begin
            freq_r <= '0;
            if (fromKeypad_r && dbDelay_r != 8'h00) begin
              state_r <= jdbms_pkg::ST_COAST; // see R14
            end else begin
              state_r <= jdbms_pkg::ST_BRAKE; // see R12 R13
            end
          end else if (rampTick) begin
            freq_r <= rampTo(freq_r, target);
          end
        end
        jdbms_pkg::ST_JOG: begin
          if (!jogRunCmd) begin
            case (jogStop_r) // see R5 R8
              jdbms_pkg::JOG_STOP_DECEL: state_r <= jdbms_pkg::ST_DECEL;
              jdbms_pkg::JOG_STOP_DC_BRAKE: begin
                freq_r <= '0;
                state_r <= jdbms_pkg::ST_JOG_BRAKE;
              end
              default: begin
                freq_r <= '0;
                state_r <= jdbms_pkg::ST_IDLE;
              end
            endcase
          end else begin
            freq_r <= jogLim; // see R2 R4
          end
        end
        jdbms_pkg::ST_DECEL: begin
          if (freq_r == 16'h0000) begin
            state_r <= jdbms_pkg::ST_IDLE;
          end else if (rampTick) begin
            freq_r <= rampTo(freq_r, 16'h0000);
          end
        end
        jdbms_pkg::ST_COAST: begin
          if (!dbIn) begin
            state_r <= jdbms_pkg::ST_LOCKOUT; // see R14
          end else if (delayDone) begin
            state_r <= jdbms_pkg::ST_BRAKE; // see R14
          end
        end
        jdbms_pkg::ST_BRAKE: begin
          if (!dbIn) begin
            if (fromKeypad_r) begin
              state_r <= jdbms_pkg::ST_LOCKOUT; // see R13
            end else if (normalRun) begin
              state_r <= jdbms_pkg::ST_RUN; // see R12
            end else begin
              state_r <= jdbms_pkg::ST_IDLE;
            end
          end
        end
        jdbms_pkg::ST_JOG_BRAKE: begin
          if (delayDone) begin
            state_r <= jdbms_pkg::ST_IDLE; // see R5
          end
        end
        jdbms_pkg::ST_LOCKOUT: begin
          if (!pins_r.keypadRun) begin
            state_r <= jdbms_pkg::ST_IDLE; // see R13
          end
        end
        default: state_r <= jdbms_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage command
  always_ff @(posedge clk) begin
    logic runOn;
    logic brakeOn;
    runOn = (state_r == jdbms_pkg::ST_RUN) || (state_r == jdbms_pkg::ST_JOG) || (state_r == jdbms_pkg::ST_DECEL);
    brakeOn = (state_r == jdbms_pkg::ST_BRAKE) || (state_r == jdbms_pkg::ST_JOG_BRAKE) ||
              ((state_r == jdbms_pkg::ST_IDLE) && dbIn); // see R9
    if (reset) begin
      drive_r <= '0;
    end else begin
      drive_r.freq <= runOn ? freq_r : 16'h0000;
      drive_r.outEnable <= runOn;
      drive_r.brakeOn <= brakeOn;
      drive_r.brakeForce <= brakeOn ? dbForce_r : 7'h00; // see R11
      drive_r.motorSet2 <= set2_r;
      drive_r.jogActive <= (state_r == jdbms_pkg::ST_JOG);
    end
  end

  assign driveOut = drive_r;

endmodule

/* File: src/jdbms_pkg.sv */
package jdbms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DB_DELAY_UNIT_NS = 100_000_000;
  localparam int DB_TICK_CYCLES = DB_DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int RAMP_TICK_NS = 1_000_000;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADR_FUNC_LO = 8'h00;
  localparam logic [7:0] ADR_FUNC_HI = 8'h04;
  localparam logic [7:0] ADR_JOG_FREQ = 8'h08;
  localparam logic [7:0] ADR_JOG_STOP = 8'h0C;
  localparam logic [7:0] ADR_RUN_SRC = 8'h10;
  localparam logic [7:0] ADR_START_FREQ = 8'h14;
  localparam logic [7:0] ADR_DB_DELAY = 8'h18;
  localparam logic [7:0] ADR_DB_FORCE = 8'h1C;
  localparam logic [7:0] ADR_MOTOR1_FREQ = 8'h20;
  localparam logic [7:0] ADR_MOTOR2_FREQ = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Status field positions
  localparam int STAT_FREQ_LSB = 0;
  localparam int STAT_OUT_EN_BIT = 16;
  localparam int STAT_BRAKE_BIT = 17;
  localparam int STAT_SET2_BIT = 18;
  localparam int STAT_STATE_LSB = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Codes, limits and reset values (frequency in 0.01 Hz, delay in 0.1 s)
  localparam int NUM_TERMINALS = 5;
  localparam logic [7:0] FUNC_JOG = 8'h06;
  localparam logic [7:0] FUNC_DC_BRAKE = 8'h07;
  localparam logic [7:0] FUNC_MOTOR2 = 8'h08;
  localparam logic [15:0] JOG_FREQ_LIMIT = 16'h03E8;
  localparam logic [1:0] JOG_STOP_COAST = 2'h0;
  localparam logic [1:0] JOG_STOP_DECEL = 2'h1;
  localparam logic [1:0] JOG_STOP_DC_BRAKE = 2'h2;
  localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;
  localparam logic [7:0] DB_DELAY_MAX = 8'h32;
  localparam logic [6:0] DB_FORCE_MAX = 7'h64;
  localparam logic [15:0] RAMP_STEP = 16'h000A;
  localparam logic [7:0] RST_FUNC_CODE = 8'h00;
  localparam logic [15:0] RST_JOG_FREQ = 16'h01F4;
  localparam logic [1:0] RST_JOG_STOP = 2'h0;
  localparam logic [1:0] RST_RUN_SRC = 2'h1;
  localparam logic [15:0] RST_START_FREQ = 16'h0032;
  localparam logic [7:0] RST_DB_DELAY = 8'h00;
  localparam logic [6:0] RST_DB_FORCE = 7'h00;
  localparam logic [15:0] RST_MOTOR_FREQ = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_JOG, ST_DECEL, ST_COAST, ST_BRAKE, ST_JOG_BRAKE, ST_LOCKOUT
  } jdbms_state_t;

  typedef struct packed {
    logic [15:0] freq;
    logic outEnable;
    logic brakeOn;
    logic [6:0] brakeForce;
    logic motorSet2;
    logic jogActive;
  } jdbms_drive_t;

  typedef struct packed {
    logic forwardRun;
    logic reverseRun;
    logic keypadRun;
    logic [NUM_TERMINALS-1:0] terminal;
  } jdbms_pins_t;

endpackage

/* File: verification/jdbms_chk.sv */
`timescale 1ns/1ps
module jdbms_chk #(
  parameter int DB_TICK_CYCLES = 10,
  parameter int RAMP_TICK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire jdbms_pkg::jdbms_pins_t pinsIn,
  input wire jdbms_pkg::jdbms_drive_t driveOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_steady;
    (driveOut.outEnable && !driveOut.jogActive) [*2];
  endsequence
  sequence s_running;
    driveOut.outEnable [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_jog_limit: assert property (driveOut.jogActive |-> driveOut.freq <= jdbms_pkg::JOG_FREQ_LIMIT)
    else $error("jog frequency above limit");
  a_jog_step: assert property ($rose(driveOut.jogActive) |-> driveOut.outEnable && driveOut.freq != 16'h0000)
    else $error("jog started without output");
  a_off_quiet: assert property (!driveOut.outEnable |-> driveOut.freq == 16'h0000)
    else $error("frequency while output off");
  a_brake_cut: assert property (driveOut.brakeOn |-> !driveOut.outEnable && driveOut.brakeForce <= jdbms_pkg::DB_FORCE_MAX)
    else $error("brake with output or force too high");
  a_force_idle: assert property (!driveOut.brakeOn |-> driveOut.brakeForce == 7'h00)
    else $error("force without braking");
  a_set_latched: assert property (s_running |-> $stable(driveOut.motorSet2))
    else $error("parameter set changed while running");
  a_ramp_rate: assert property (s_steady |-> {1'b0, driveOut.freq} <= {1'b0, $past(driveOut.freq)} + 17'h0000A)
    else $error("ramp step too large");
endmodule

bind jdbms_jog_brake_ctrl jdbms_chk #(.DB_TICK_CYCLES(DB_TICK_CYCLES), .RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) chk (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pinsIn(pinsIn),
  .driveOut(driveOut));

/* File: verification/jdbms_partner.sv */
`timescale 1ns/1ps
module jdbms_partner #(
  parameter int BRAKE_LIMIT = 2000
) (
  input wire logic clk,
  input wire jdbms_pkg::jdbms_pins_t req,
  input wire jdbms_pkg::jdbms_drive_t drive,
  output jdbms_pkg::jdbms_pins_t pinsIn,
  output logic overBrake
);
  int brakeCount;
  initial begin
    pinsIn = '0;
    overBrake = 1'b0;
    brakeCount = 0;
  end
  // Contacts close one edge after the bench asks
  always @(posedge clk) begin
    pinsIn <= req;
  end
  // Output stage flags a brake held like a holding brake
  always @(posedge clk) begin
    brakeCount <= drive.brakeOn ? brakeCount + 1 : 0;
    if (brakeCount > BRAKE_LIMIT) begin
      overBrake <= 1'b1;
    end
  end
endmodule

/* File: verification/test_jog_dc_brake_motor_select.sv */
`timescale 1ns/1ps
module test_jog_dc_brake_motor_select;
  logic clk, reset, cyc, stb, we, ack, overBrake;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] j;
  jdbms_pkg::jdbms_pins_t req, pins;
  jdbms_pkg::jdbms_drive_t drv;
  int mismatches, compares;
  localparam logic [26:0] M_F = 27'h7FFF800;
  localparam logic [26:0] M_OFF = 27'h0000600;
  localparam logic [31:0] RSTV [11] = '{32'h0, 32'h0, 32'h1F4, 32'h0, 32'h1, 32'h32, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};

  jdbms_jog_brake_ctrl #(.DB_TICK_CYCLES(10), .RAMP_TICK_CYCLES(4)) uut (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pinsIn(pins), .driveOut(drv));
  jdbms_partner #(.BRAKE_LIMIT(2000)) far (.clk(clk), .req(req), .drive(drv), .pinsIn(pins),
    .overBrake(overBrake));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      cmp("bus ack", 32'h1, 32'h0);
      report_and_stop;
    end
  endtask

  task automatic waitDrive(input logic [26:0] m, input logic [26:0] v);
    int n;
    n = 0;
    while ((drv & m) !== v) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        cmp("drive wait", 32'(v), 32'(drv & m));
        report_and_stop;
      end
    end
  endtask

  function automatic logic [26:0] fq(input logic [15:0] f);
    return {f, 11'h000};
  endfunction

  function automatic logic [15:0] jogExp(input logic [15:0] v, input logic [15:0] s);
    if (v == 16'h0000 || v < s) return 16'h0000;
    return (v > jdbms_pkg::JOG_FREQ_LIMIT) ? jdbms_pkg::JOG_FREQ_LIMIT : v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    req = '0;
    mismatches = 0;
    compares = 0;
    void'($urandom(55226));
    tick(2);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      cmp("reset value", RSTV[i], q);
    end
    bus(1'b1, 8'h30, 32'hFFFFFFFF);
    bus(1'b0, 8'h30, 32'h0);
    cmp("unmapped", 32'h0, q);
    bus(1'b1, jdbms_pkg::ADR_DB_DELAY, 32'h100);
    bus(1'b0, jdbms_pkg::ADR_DB_DELAY, 32'h0);
    cmp("delay clamp", 32'h32, q);
    bus(1'b1, jdbms_pkg::ADR_DB_FORCE, 32'h80);
    bus(1'b0, jdbms_pkg::ADR_DB_FORCE, 32'h0);
    cmp("force clamp", 32'h64, q);
    bus(1'b1, jdbms_pkg::ADR_DB_DELAY, 32'h2);
    bus(1'b1, jdbms_pkg::ADR_DB_FORCE, 32'h28);
    bus(1'b1, jdbms_pkg::ADR_FUNC_LO, 32'h00060007);
    bus(1'b1, jdbms_pkg::ADR_FUNC_HI, 32'h08);
    bus(1'b1, jdbms_pkg::ADR_MOTOR2_FREQ, 32'hC8);
    $display("test registers done");
    req.terminal[2] <= 1'b1;
    tick(8);
    cmp("jog without run", 32'h0, 32'(drv.freq));
    for (int i = 0; i < 6; i++) begin
      j = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0031 : (i == 2) ? 16'h03E9 : 16'($urandom_range(4000, 1));
      bus(1'b1, jdbms_pkg::ADR_JOG_FREQ, {16'h0000, j});
      req.forwardRun <= 1'b1;
      tick(8);
      cmp("jog freq", 32'(jogExp(j, 16'h0032)), 32'(drv.freq));
      cmp("jog flag", 32'(jogExp(j, 16'h0032) != 16'h0000), 32'(drv.jogActive));
      req.forwardRun <= 1'b0;
      waitDrive(M_OFF, 27'h0);
      tick(4);
    end
    bus(1'b1, jdbms_pkg::ADR_JOG_FREQ, 32'h1F4);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, jdbms_pkg::ADR_JOG_STOP, 32'(m));
      req.terminal[2] <= 1'b1;
      req.forwardRun <= 1'b1;
      tick(8);
      req.terminal[2] <= 1'b0;
      req.forwardRun <= 1'b0;
      tick(8);
      cmp("stop output", 32'(m == 1), 32'(drv.outEnable));
      cmp("stop brake", 32'(m == 2), 32'(drv.brakeOn));
      cmp("stop force", (m == 2) ? 32'h28 : 32'h0, 32'(drv.brakeForce));
      waitDrive(M_OFF, 27'h0);
    end
    bus(1'b1, jdbms_pkg::ADR_RUN_SRC, 32'h0);
    req.terminal[2] <= 1'b1;
    req.keypadRun <= 1'b1;
    tick(8);
    cmp("key jog refused", 32'h0, 32'(drv.jogActive));
    bus(1'b1, jdbms_pkg::ADR_RUN_SRC, 32'h1);
    tick(8);
    cmp("key jog taken", 32'h1, 32'(drv.jogActive));
    req.terminal[2] <= 1'b0;
    req.keypadRun <= 1'b0;
    waitDrive(M_OFF, 27'h0);
    $display("test jog done");
    bus(1'b1, jdbms_pkg::ADR_MOTOR1_FREQ, 32'h64);
    req.forwardRun <= 1'b1;
    waitDrive(M_F, fq(16'h0064));
    req.terminal[0] <= 1'b1;
    tick(8);
    cmp("run brake", 32'h1, 32'(drv.brakeOn));
    cmp("run force", 32'h28, 32'(drv.brakeForce));
    req.terminal[0] <= 1'b0;
    tick(8);
    cmp("resume", 32'h1, 32'(drv.outEnable));
    waitDrive(M_F, fq(16'h0064));
    req.forwardRun <= 1'b0;
    waitDrive(M_OFF, 27'h0);
    bus(1'b1, jdbms_pkg::ADR_RUN_SRC, 32'h0);
    req.keypadRun <= 1'b1;
    waitDrive(M_F, fq(16'h0064));
    req.terminal[0] <= 1'b1;
    tick(8);
    cmp("coast first", 32'h0, {30'h0, drv.outEnable, drv.brakeOn});
    tick(22);
    cmp("late brake", 32'h1, 32'(drv.brakeOn));
    req.terminal[0] <= 1'b0;
    tick(8);
    cmp("stay off", 32'h0, 32'(drv.outEnable));
    tick(40);
    cmp("still off", 32'h0, 32'(drv.outEnable));
    req.keypadRun <= 1'b0;
    tick(8);
    $display("test brake done");
    bus(1'b1, jdbms_pkg::ADR_RUN_SRC, 32'h1);
    req.forwardRun <= 1'b1;
    waitDrive(M_F, fq(16'h0064));
    req.terminal[4] <= 1'b1;
    tick(8);
    cmp("set held", 32'h0, 32'(drv.motorSet2));
    cmp("set freq held", 32'h64, 32'(drv.freq));
    req.forwardRun <= 1'b0;
    waitDrive(M_OFF, 27'h0);
    tick(8);
    req.forwardRun <= 1'b1;
    waitDrive(M_F, fq(16'h00C8));
    cmp("set two", 32'h1, 32'(drv.motorSet2));
    req.terminal[4] <= 1'b0;
    req.forwardRun <= 1'b0;
    waitDrive(M_OFF, 27'h0);
    tick(8);
    req.reverseRun <= 1'b1;
    waitDrive(M_F, fq(16'h0064));
    bus(1'b0, jdbms_pkg::ADR_STATUS, 32'h0);
    cmp("status", 32'h00010064, q & 32'h0007FFFF);
    cmp("holding brake", 32'h0, 32'(overBrake));
    $display("test motor set done");
    report_and_stop;
  end
endmodule
